/* File: design/smf_front.sv */
// Serial command front end of a byte-addressed serial memory.
//
// Summary of operation
// - Input on rising edges, output on falling.
// - Clock level at select picks mode.
// - First byte is opcode, rest follow.
// - One opcode per chip select low period.
// - Deselected: input ignored, output undriven.
// - All bytes shift most significant first.
// - Two address bytes, low 13 bits used.
// - Invalid opcode: ignore rest, output undriven.
// - Decode set and clear latch opcodes.
// - Decode status read and status write.
// - Decode memory read and write; others invalid.
// - Eight-bit status byte returned on read.
// - Latch clear after reset.
// - Only set opcode sets latch flag.
// - Latch clears at select end of writes.
// - Clear command blocks writes, flag reads zero.
// - Status layout: bits 7, 3, 2, 1 live.
// - Block protect codes guard upper ranges.
// - Burst address increments and wraps.
// - Read data follows address; input ignored.
`timescale 1ns/1ps
module smf_front (
   // Reference clock and reset
   input  wire logic              ref_clk,
   input  wire logic              rst,
   // Serial link
   input  wire logic              sck_clk,
   input  wire logic              cs_n,
   input  wire logic              si,
   output logic                   so,
   output logic                   so_oe,
   // Memory array port
   output logic                   mem_rd,
   output logic                   mem_wr,
   output logic [12:0]            mem_addr,
   output logic [7:0]             mem_wdata,
   input  wire logic [7:0]        mem_rd_data,
   // Status and command reporting
   output logic                   write_latch_flag,
   output logic                   protect_pin_enable,
   output logic                   block_protect_hi,
   output logic                   block_protect_lo,
   output logic                   spi_mode3,
   output logic                   cmd_strobe,
   output smf_pkg::smf_cmd_e      cmd_code
);

   // ==========================================================================
   // Reference domain state
   // ==========================================================================
   typedef struct packed {
      logic              cs_prev;    // Synchronised select, one cycle old.
      logic [1:0]        gray_seen;  // Byte count already handled.
      logic [1:0]        idx;        // Byte index in selection, stops at 3.
      smf_pkg::smf_cmd_e cmd;        // Command of this selection.
      logic [12:0]       addr;       // Burst address counter.
      logic              latch;      // Write enable latch.
      logic              ppe;        // Protect pin enable bit.
      logic              bp_hi;      // Block protect high bit.
      logic              bp_lo;      // Block protect low bit.
      logic              mode3;      // Clock was high at selection.
      logic              wr_stop;    // Burst write hit a guarded byte.
      logic              rd_cap;     // Capture array data this cycle.
      logic [7:0]        rd_byte;    // Next byte to send on a read.
      logic              mem_rd;     // Array read strobe.
      logic              mem_wr;     // Array write strobe.
      logic [12:0]       mem_addr;   // Array address.
      logic [7:0]        mem_wdata;  // Array write data.
      logic              cmd_strobe; // Opcode decoded pulse.
   } smf_ctl_s;

   smf_ctl_s         ctl_reg;    // Registered control state.
   smf_ctl_s         ctl_next;   // Next control state.
   smf_pkg::smf_rx_s rx_reg;     // Link receive state.
   smf_pkg::smf_rx_s rx_next;    // Next link receive state.
   smf_pkg::smf_dat_s dat_reg;   // Link byte hand-off state.
   smf_pkg::smf_dat_s dat_next;  // Next hand-off state.
   smf_pkg::smf_tx_s tx_reg;     // Link transmit state.
   smf_pkg::smf_tx_s tx_next;    // Next link transmit state.
   logic [3:0]       sy_q;       // Synchronised select, clock and count.
   logic             cs_s;       // Synchronised select, high when idle.
   logic             sck_s;      // Synchronised serial clock level.
   logic [1:0]       gray_s;     // Synchronised byte count.
   logic             guarded;    // Current address is write protected.
   logic [7:0]       stat_byte;  // Status byte as read back.

   // ==========================================================================
   // Link domain: receive on rising serial clock edges
   // ==========================================================================
   // Shifts one bit per rising edge, top bit first, and closes a byte on the
   // eighth.  In mode 3 the clock starts high, so the first edge seen is a
   // falling one and the first rising edge already carries the first bit.
   always_comb begin
      rx_next = rx_reg;
      dat_next = dat_reg;
      rx_next.bit_cnt = rx_reg.bit_cnt + 3'h1;
      rx_next.shift = {rx_reg.shift[5:0], si};
      if (rx_reg.bit_cnt == 3'h7) begin
         // A whole byte: hand it over and count it in gray code.
         dat_next.byte_v = {rx_reg.shift, si};
         dat_next.gray = smf_pkg::smf_gray_inc(dat_reg.gray);
         if (rx_reg.nbytes == 2'h0) begin
            // The first byte of a selection is the opcode.
            rx_next.op = smf_pkg::smf_decode({rx_reg.shift, si});
         end
         if (rx_reg.nbytes != 2'h3) begin
            rx_next.nbytes = rx_reg.nbytes + 2'h1;
         end
      end
   end

   // Deselection restarts the byte framing and drops a partial byte.
   always_ff @(posedge sck_clk or posedge cs_n) begin
      if (cs_n) begin
         rx_reg <= '{bit_cnt: 3'h0, nbytes: 2'h0, shift: 7'h00,
                     op: smf_pkg::CMD_NONE};
      end else begin
         rx_reg <= rx_next;
      end
   end

   // The hand-off word survives deselection so the last byte is not lost.
   always_ff @(posedge sck_clk or posedge rst) begin
      if (rst) begin
         dat_reg <= '{gray: 2'h0, byte_v: 8'h00};
      end else begin
         dat_reg <= dat_next;
      end
   end

   // ==========================================================================
   // Link domain: transmit on falling serial clock edges
   // ==========================================================================
   // At each byte boundary the next output byte is loaded; otherwise the
   // byte moves up one place.  Status and read data are held still by the
   // reference side across the boundary, so they are taken as stable words.
   always_comb begin
      tx_next.shift = {tx_reg.shift[6:0], 1'b0};
      tx_next.oe = tx_reg.oe;
      if (rx_reg.bit_cnt == 3'h0 && rx_reg.nbytes != 2'h0) begin
         tx_next.shift = 8'h00;
         tx_next.oe = 1'b0;
         if (rx_reg.op == smf_pkg::CMD_STAT_RD) begin
            // Status read returns the status byte after the opcode.
            tx_next.shift = stat_byte;
            tx_next.oe = 1'b1;
         end else if (rx_reg.op == smf_pkg::CMD_MEM_RD && rx_reg.nbytes == 2'h3) begin
            // Memory read returns data once both address bytes are in.
            tx_next.shift = ctl_reg.rd_byte;
            tx_next.oe = 1'b1;
         end
      end
   end

   // Deselection releases the output line at once.
   always_ff @(negedge sck_clk or posedge cs_n) begin
      if (cs_n) begin
         tx_reg <= '{shift: 8'h00, oe: 1'b0};
      end else begin
         tx_reg <= tx_next;
      end
   end

   assign so = tx_reg.shift[7];
   assign so_oe = tx_reg.oe;

   // ==========================================================================
   // Crossing into the reference domain
   // ==========================================================================
   // Select, clock level and byte count cross as levels; the gray count
   // moves one bit per byte so it can never be caught half changed.
   // Select crosses inverted, so a cleared synchroniser reads as idle and
   // no false select edge follows reset.
   smf_sync #(
      .W (4)
   ) u_sync (
      .clk (ref_clk),
      .rst (rst),
      .d   ({~cs_n, sck_clk, dat_reg.gray}),
      .q   (sy_q)
   );

   assign cs_s = ~sy_q[3];
   assign sck_s = sy_q[2];
   assign gray_s = sy_q[1:0];

   // Guard check for the current burst address.
   smf_protect u_protect (
      .bp      ({ctl_reg.bp_hi, ctl_reg.bp_lo}),
      .addr    (ctl_reg.addr),
      .guarded (guarded)
   );

   // Assembles the status byte; unused bits stay zero.
   always_comb begin
      stat_byte = smf_pkg::STATUS_RST;
      stat_byte[smf_pkg::STB_PPE] = ctl_reg.ppe;
      stat_byte[smf_pkg::STB_BP_HI] = ctl_reg.bp_hi;
      stat_byte[smf_pkg::STB_BP_LO] = ctl_reg.bp_lo;
      stat_byte[smf_pkg::STB_WLF] = ctl_reg.latch;
   end

   // ==========================================================================
   // Reference domain: command handling
   // ==========================================================================
   // Each new byte is taken by its position in the selection.  Opcode
   // effects on the latch wait for the end of the selection.
   always_comb begin
      logic [7:0]  byt;
      logic [12:0] full;
      byt = dat_reg.byte_v;
      full = {ctl_reg.addr[12:8], byt};
      ctl_next = ctl_reg;
      ctl_next.cs_prev = cs_s;
      ctl_next.mem_rd = 1'b0;
      ctl_next.mem_wr = 1'b0;
      ctl_next.cmd_strobe = 1'b0;
      ctl_next.rd_cap = 1'b0;
      // Array data arrives one cycle after a read strobe.
      if (ctl_reg.rd_cap) begin
         ctl_next.rd_byte = mem_rd_data;
      end
      // Falling select: the clock level chooses the mode.
      if (!ctl_reg.cs_prev && cs_s) begin
         ctl_next.mode3 = 1'b0;
      end
      if (ctl_reg.cs_prev && !cs_s) begin
         ctl_next.mode3 = sck_s;
      end
      if (gray_s != ctl_reg.gray_seen) begin
         ctl_next.gray_seen = gray_s;
         if (ctl_reg.idx != 2'h3) begin
            ctl_next.idx = ctl_reg.idx + 2'h1;
         end
         if (ctl_reg.idx == 2'h0) begin
            // Opcode byte.
            ctl_next.cmd = smf_pkg::smf_decode(byt);
            ctl_next.cmd_strobe = 1'b1;
         end else begin
            // Later bytes mean something only to their own command.
            unique case (ctl_reg.cmd)
               smf_pkg::CMD_STAT_WR: begin
                  if (ctl_reg.idx == 2'h1 && ctl_reg.latch) begin
                     // Only bits 7, 3 and 2 take the written value; the latch flag bit does not.
                     ctl_next.ppe = byt[smf_pkg::STB_PPE];
                     ctl_next.bp_hi = byt[smf_pkg::STB_BP_HI];
                     ctl_next.bp_lo = byt[smf_pkg::STB_BP_LO];
                  end
               end
               smf_pkg::CMD_MEM_RD: begin
                  if (ctl_reg.idx == 2'h1) begin
                     // Top three address bits are dropped.
                     ctl_next.addr[12:8] = byt[4:0];
                  end else if (ctl_reg.idx == 2'h2) begin
                     // Fetch the first byte and point past it.
                     ctl_next.mem_rd = 1'b1;
                     ctl_next.mem_addr = full;
                     ctl_next.addr = full + 13'h0001;
                     ctl_next.rd_cap = 1'b1;
                  end else begin
                     // Input bytes are ignored; fetch the next byte.
                     ctl_next.mem_rd = 1'b1;
                     ctl_next.mem_addr = ctl_reg.addr;
                     ctl_next.addr = ctl_reg.addr + 13'h0001;
                     ctl_next.rd_cap = 1'b1;
                  end
               end
               smf_pkg::CMD_MEM_WR: begin
                  if (ctl_reg.idx == 2'h1) begin
                     ctl_next.addr[12:8] = byt[4:0];
                  end else if (ctl_reg.idx == 2'h2) begin
                     ctl_next.addr = full;
                  end else if (ctl_reg.latch) begin
                     if (guarded || ctl_reg.wr_stop) begin
                        // A guarded byte ends the burst for good.
                        ctl_next.wr_stop = 1'b1;
                     end else begin
                        ctl_next.mem_wr = 1'b1;
                        ctl_next.mem_addr = ctl_reg.addr;
                        ctl_next.mem_wdata = byt;
                        ctl_next.addr = ctl_reg.addr + 13'h0001;
                     end
                  end
               end
               default: begin
                  // Latch commands, status read and invalid opcodes
                  // take no further bytes.
                  ctl_next.cmd = ctl_reg.cmd;
               end
            endcase
         end
      end
      // Rising select ends the command and applies latch effects.
      if (!ctl_reg.cs_prev && cs_s) begin
         if (ctl_next.cmd == smf_pkg::CMD_SET_LATCH) begin
            ctl_next.latch = 1'b1;
         end else if (ctl_next.cmd == smf_pkg::CMD_CLR_LATCH ||
                      ctl_next.cmd == smf_pkg::CMD_STAT_WR ||
                      ctl_next.cmd == smf_pkg::CMD_MEM_WR) begin
            ctl_next.latch = 1'b0;
         end
         ctl_next.idx = 2'h0;
         ctl_next.cmd = smf_pkg::CMD_NONE;
         ctl_next.wr_stop = 1'b0;
      end
   end

   // Registers control state; reset leaves the latch clear.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         ctl_reg <= '{cs_prev: 1'b1, gray_seen: 2'h0, idx: 2'h0,
                      cmd: smf_pkg::CMD_NONE, addr: smf_pkg::ADDR_FIRST,
                      latch: 1'b0, ppe: 1'b0, bp_hi: 1'b0, bp_lo: 1'b0,
                      mode3: 1'b0, wr_stop: 1'b0, rd_cap: 1'b0,
                      rd_byte: 8'h00, mem_rd: 1'b0, mem_wr: 1'b0,
                      mem_addr: smf_pkg::ADDR_FIRST, mem_wdata: 8'h00,
                      cmd_strobe: 1'b0};
      end else begin
         ctl_reg <= ctl_next;
      end
   end

   // ==========================================================================
   // Outputs, each straight from a flip-flop
   // ==========================================================================
   assign mem_rd = ctl_reg.mem_rd;
   assign mem_wr = ctl_reg.mem_wr;
   assign mem_addr = ctl_reg.mem_addr;
   assign mem_wdata = ctl_reg.mem_wdata;
   assign write_latch_flag = ctl_reg.latch;
   assign protect_pin_enable = ctl_reg.ppe;
   assign block_protect_hi = ctl_reg.bp_hi;
   assign block_protect_lo = ctl_reg.bp_lo;
   assign spi_mode3 = ctl_reg.mode3;
   assign cmd_strobe = ctl_reg.cmd_strobe;
   assign cmd_code = ctl_reg.cmd;

endmodule

/* File: design/smf_pkg.sv */
// Shared constants, command codes and state carriers of the serial memory front end.
package smf_pkg;

   // ==========================================================================
   // Widths
   // ==========================================================================
   localparam int ADDR_W = 13;          // Used byte address bits.
   localparam int BYTE_W = 8;           // Bits per serial byte.

   // ==========================================================================
   // Opcodes
   // ==========================================================================
   localparam logic [7:0] OPC_SET_LATCH = 8'h06;
   localparam logic [7:0] OPC_CLR_LATCH = 8'h04;
   localparam logic [7:0] OPC_STAT_RD   = 8'h05;
   localparam logic [7:0] OPC_STAT_WR   = 8'h01;
   localparam logic [7:0] OPC_MEM_RD    = 8'h03;
   localparam logic [7:0] OPC_MEM_WR    = 8'h02;

   // ==========================================================================
   // Status byte layout and reset value
   // ==========================================================================
   localparam int         STB_PPE    = 7;      // Protect pin enable.
   localparam int         STB_BP_HI  = 3;      // Block protect, high bit.
   localparam int         STB_BP_LO  = 2;      // Block protect, low bit.
   localparam int         STB_WLF    = 1;      // Write latch flag.
   localparam logic [7:0] STATUS_RST = 8'h00;  // Every bit clear after reset.

   // ==========================================================================
   // Address space and protected ranges
   // ==========================================================================
   localparam logic [12:0] PROT_QTR_BASE  = 13'h1800;
   localparam logic [12:0] PROT_HALF_BASE = 13'h1000;
   localparam logic [12:0] ADDR_LAST      = 13'h1fff;
   localparam logic [12:0] ADDR_FIRST     = 13'h0000;

   // ==========================================================================
   // Commands
   // ==========================================================================
   typedef enum logic [2:0] {
      CMD_NONE, CMD_SET_LATCH, CMD_CLR_LATCH, CMD_STAT_RD,
      CMD_STAT_WR, CMD_MEM_RD, CMD_MEM_WR, CMD_BAD
   } smf_cmd_e;

   // Turns an opcode byte into a command; any other value is invalid.
   function automatic smf_cmd_e smf_decode(input logic [7:0] b);
      case (b)
         OPC_SET_LATCH: smf_decode = CMD_SET_LATCH;
         OPC_CLR_LATCH: smf_decode = CMD_CLR_LATCH;
         OPC_STAT_RD:   smf_decode = CMD_STAT_RD;
         OPC_STAT_WR:   smf_decode = CMD_STAT_WR;
         OPC_MEM_RD:    smf_decode = CMD_MEM_RD;
         OPC_MEM_WR:    smf_decode = CMD_MEM_WR;
         default:       smf_decode = CMD_BAD;
      endcase
   endfunction

   // Steps a two-bit gray count: 00, 01, 11, 10.
   function automatic logic [1:0] smf_gray_inc(input logic [1:0] g);
      smf_gray_inc = {g[0], ~g[1]};
   endfunction

   // ==========================================================================
   // State carriers
   // ==========================================================================
   typedef struct packed {
      logic [2:0] bit_cnt;   // Bits received in the current byte.
      logic [1:0] nbytes;    // Whole bytes in this selection, stops at 3.
      logic [6:0] shift;     // Bits of the byte being received.
      smf_cmd_e   op;        // Command of this selection.
   } smf_rx_s;

   typedef struct packed {
      logic [1:0] gray;      // Count of whole bytes, gray coded.
      logic [7:0] byte_v;    // Last whole byte.
   } smf_dat_s;

   typedef struct packed {
      logic [7:0] shift;     // Output byte, top bit on the line.
      logic       oe;        // Output line driven.
   } smf_tx_s;

endpackage

/* File: design/smf_protect.sv */
// Block protection decoder: tells whether a byte address is guarded.
`timescale 1ns/1ps
module smf_protect (
   // Protection code and address
   input  wire logic [1:0]  bp,
   input  wire logic [12:0] addr,
   // Result
   output logic             guarded
);
   // Selects the guarded range from the two-bit code.
   always_comb begin
      unique case (bp)
         2'b00: guarded = 1'b0;
         2'b01: guarded = (addr >= smf_pkg::PROT_QTR_BASE);
         2'b10: guarded = (addr >= smf_pkg::PROT_HALF_BASE);
         2'b11: guarded = 1'b1;
      endcase
   end
endmodule

/* File: design/smf_sync.sv */
// Two-stage synchroniser for levels entering the reference clock domain.
`timescale 1ns/1ps
module smf_sync #(
   parameter int W = 1
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         rst,
   // Levels in and out
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0] s1;  // First stage, read only by the second.
      logic [W-1:0] s2;  // Second stage, safe to use.
   } smf_sy_s;

   smf_sy_s sy_reg;   // Registered stages.
   smf_sy_s sy_next;  // Next value of the stages.

   // Shifts the input through both stages.
   always_comb begin
      sy_next.s1 = d;
      sy_next.s2 = sy_reg.s1;
   end

   // Registers the stages; reset clears them.
   always_ff @(posedge clk) begin
      if (rst) begin
         sy_reg <= '0;
      end else begin
         sy_reg <= sy_next;
      end
   end

   assign q = sy_reg.s2;
endmodule

/* File: verif/smf_front_monitor.sv */
// Checker of the serial memory front end, bound to its top module.
`timescale 1ns/1ps
module smf_front_monitor (
   // Watched ports
   input wire logic          ref_clk, rst, cs_n, so_oe, mem_rd, mem_wr, cmd_strobe,
   input wire logic          write_latch_flag, block_protect_hi, block_protect_lo, spi_mode3,
   input wire logic [12:0]   mem_addr,
   input smf_pkg::smf_cmd_e  cmd_code
);
   // ==========================================================================
   // Helpers
   // ==========================================================================
   logic [1:0] bp;  // Block protect code.
   assign bp = {block_protect_hi, block_protect_lo};
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   property p_oe_idle; cs_n |-> !so_oe; endproperty
   a_oe_idle: assert property (p_oe_idle) else $error("so_oe high while deselected");
   property p_bad; cmd_code == smf_pkg::CMD_BAD |-> !so_oe && !mem_rd && !mem_wr; endproperty
   a_bad: assert property (p_bad) else $error("activity after invalid opcode");
   property p_strobe;
      cmd_strobe |-> cmd_code != smf_pkg::CMD_NONE ##1 (!cmd_strobe && $stable(cmd_code)) [*3];
   endproperty
   a_strobe: assert property (p_strobe) else $error("opcode strobe not single");
   property p_rd; mem_rd |-> cmd_code == smf_pkg::CMD_MEM_RD; endproperty
   a_rd: assert property (p_rd) else $error("array read outside read command");
   property p_wr; mem_wr |-> cmd_code == smf_pkg::CMD_MEM_WR && write_latch_flag; endproperty
   a_wr: assert property (p_wr) else $error("array write without latch");
   property p_guard;
      mem_wr |-> !(bp == 2'h3 || (bp == 2'h2 && mem_addr[12]) || (bp == 2'h1 && &mem_addr[12:11]));
   endproperty
   a_guard: assert property (p_guard) else $error("write into guarded range");
   property p_idle; cs_n [*6] |-> !spi_mode3 && cmd_code == smf_pkg::CMD_NONE; endproperty
   a_idle: assert property (p_idle) else $error("framing not cleared at deselect");
   property p_latch; (!cs_n) [*6] |-> $stable(write_latch_flag); endproperty
   a_latch: assert property (p_latch) else $error("latch moved inside selection");
endmodule
bind smf_front smf_front_monitor u_mon (.*);

/* File: verif/smf_master.sv */
// Bus master model driving the serial link of the front end.
`timescale 1ns/1ps
module smf_master (
   // Link pins
   output logic      sck_clk, cs_n, si,
   input  wire logic so, so_oe
);
   logic mode3 = 1'b0;             // Idle clock level of this frame.
   logic last  = 1'b0;             // Last level seen on the data line.
   wire  line  = so_oe ? so : ~last;  // An undriven line keeps changing.
   initial begin
      sck_clk = 1'b0; cs_n = 1'b1; si = 1'b0;
   end
   always @(posedge sck_clk) last <= line;
   // Parks the clock at the mode's idle level, then selects.
   task automatic open_frame(input logic m);
      mode3 = m; sck_clk = m; #90 cs_n = 1'b0; #90;
   endtask
   // Shifts a byte each way, top bit first, pausing high after the last edge.
   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) begin
         sck_clk = 1'b0; si = tx[i]; #32 sck_clk = 1'b1; rx[i] = line; #(i ? 32 : 400);
      end
   endtask
   // Shifts only the top n bits of a byte and stops with the clock high.
   task automatic part(input logic [7:0] tx, input int n);
      for (int i = 7; i > 7 - n; i--) begin
         sck_clk = 1'b0; si = tx[i]; #32 sck_clk = 1'b1; #32;
      end
   endtask
   // Returns the clock to idle and deselects; input then toggles meaningless.
   task automatic close_frame();
      sck_clk = mode3; #200 cs_n = 1'b1; si = ~si; #200;
   endtask
endmodule

/* File: verif/tb_smf_front.sv */
// Self-checking bench of the serial memory front end.
`timescale 1ns/1ps
module tb_smf_front;
   logic ref_clk = 1'b0, rst = 1'b1, sck_clk, cs_n, si, so, so_oe, mem_rd, mem_wr;
   logic write_latch_flag, protect_pin_enable, block_protect_hi, block_protect_lo;
   logic spi_mode3, cmd_strobe;
   logic [12:0] mem_addr;
   logic [7:0]  mem_wdata, rx, mem_rd_data = 8'h00;
   logic [20:0] last_wr = 21'h0_0000;  // Address and data of the last array write.
   smf_pkg::smf_cmd_e cmd_code;
   int n_errors = 0, checks_done = 0, n_wr = 0, cyc = 0, w0;
   smf_front DUT (.*);
   smf_master u_master (.sck_clk(sck_clk), .cs_n(cs_n), .si(si), .so(so), .so_oe(so_oe));
   initial forever #20 ref_clk = ~ref_clk;
   // Array model: read data is a pattern of the address; writes are logged.
   always @(negedge ref_clk) mem_rd_data <= mem_addr[7:0] ^ 8'h3c;
   always @(posedge ref_clk) if (mem_wr === 1'b1) begin
      n_wr <= n_wr + 1; last_wr <= {mem_addr, mem_wdata};
   end
   always @(posedge ref_clk) if (++cyc == 6000) begin
      n_errors++; tally_and_finish();
   end
   task automatic chk(input string what, input logic [20:0] got, exp);
      checks_done++;
      if (got !== exp) begin
         n_errors++; $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic frame(input logic m, input logic [7:0] b[$]);
      u_master.open_frame(m);
      foreach (b[i]) u_master.xfer(b[i], rx);
      u_master.close_frame();
   endtask
   // Reads the status byte in the given mode and checks mode and content.
   task automatic st_exp(input logic m, input logic [7:0] e);
      u_master.open_frame(m);
      u_master.xfer(smf_pkg::OPC_STAT_RD, rx);
      chk("mode", spi_mode3, m);
      chk("code", cmd_code, smf_pkg::CMD_STAT_RD);
      u_master.xfer(8'h00, rx);
      u_master.close_frame();
      chk("status", rx, e);
   endtask
   task automatic tally_and_finish();
      if (n_errors == 0 && checks_done > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   initial begin
      repeat (10) @(posedge ref_clk);
      @(negedge ref_clk) rst = 1'b0;
      repeat (3) @(negedge ref_clk);
      st_exp(1'b0, 8'h00);
      frame(1'b1, {smf_pkg::OPC_STAT_WR, 8'hff});
      st_exp(1'b1, 8'h00);
      frame(1'b0, {smf_pkg::OPC_SET_LATCH});
      st_exp(1'b1, 8'h02);
      frame(1'b1, {smf_pkg::OPC_STAT_WR, 8'hff});
      st_exp(1'b0, 8'h8c);
      chk("protect pin enable", protect_pin_enable, 1'b1);
      frame(1'b0, {smf_pkg::OPC_SET_LATCH});
      frame(1'b0, {smf_pkg::OPC_CLR_LATCH});
      st_exp(1'b0, 8'h8c);
      frame(1'b0, {smf_pkg::OPC_SET_LATCH});
      frame(1'b0, {smf_pkg::OPC_STAT_WR, 8'h00});
      w0 = n_wr;
      frame(1'b0, {smf_pkg::OPC_MEM_WR, 8'h00, 8'h10, 8'h55});
      chk("unlatched writes", 21'(n_wr - w0), 21'h0_0000);
      frame(1'b1, {smf_pkg::OPC_SET_LATCH});
      frame(1'b1, {smf_pkg::OPC_MEM_WR, 8'hff, 8'hff, 8'ha1, 8'hb2});
      chk("burst writes", 21'(n_wr - w0), 21'h0_0002);
      chk("wrap write", last_wr, {13'h0000, 8'hb2});
      chk("latch after write", write_latch_flag, 1'b0);
      frame(1'b0, {smf_pkg::OPC_SET_LATCH});
      frame(1'b0, {smf_pkg::OPC_STAT_WR, 8'h04});
      frame(1'b0, {smf_pkg::OPC_SET_LATCH});
      frame(1'b0, {smf_pkg::OPC_MEM_WR, 8'h17, 8'hff, 8'h11, 8'h22, 8'h33});
      chk("guarded burst", 21'(n_wr - w0), 21'h0_0003);
      chk("last unguarded", last_wr, {13'h17ff, 8'h11});
      frame(1'b1, {smf_pkg::OPC_MEM_RD, 8'hff, 8'hfe, 8'h00, 8'h00, 8'h00});
      chk("read wrap", rx, 8'h3c);
      frame(1'b0, {8'ha5, smf_pkg::OPC_SET_LATCH});
      chk("invalid opcode", write_latch_flag, 1'b0);
      u_master.open_frame(1'b0);
      u_master.part(8'h00, 7);
      u_master.close_frame();
      frame(1'b0, {smf_pkg::OPC_SET_LATCH});
      chk("after partial byte", write_latch_flag, 1'b1);
      tally_and_finish();
   end
endmodule
